// ---- hdl/die_temperature_guard_pkg.sv ----
/*
  Shared constants for the die temperature guard: thresholds, repeat period,
  sensor source codes and condition states.
  Assumes a single core clock at 125 MHz and temperatures in signed whole degrees.
*/
package die_temperature_guard_pkg;
  // ==========================================================================
  // temperature format
  localparam int TEMP_W = 8;
  // ==========================================================================
  // thresholds, degrees Celsius
  localparam logic signed [TEMP_W-1:0] WARN_SET_DEGC = 8'sd87;
  localparam logic signed [TEMP_W-1:0] WARN_CLEAR_DEGC = 8'sd83;
  localparam logic signed [TEMP_W-1:0] WARN_ABOVE_DEGC = 8'sd103;
  localparam logic signed [TEMP_W-1:0] ERR_SET_DEGC = 8'sd103;
  localparam logic signed [TEMP_W-1:0] ERR_CLEAR_DEGC = 8'sd97;
  // ==========================================================================
  // timing
  localparam longint CLK_HZ = 125000000;
  localparam longint REPEAT_PERIOD_MS = 1000;
  localparam longint REPEAT_CYCLES = (CLK_HZ * REPEAT_PERIOD_MS) / 1000;
  localparam int TIMER_W = 32;
  // ==========================================================================
  // sensor source selection
  localparam int SRC_W = 2;
  localparam logic [SRC_W-1:0] SRC_OWN_DIE = 2'h0;
  localparam logic [SRC_W-1:0] SRC_RESET = 2'h0;
  localparam logic signed [TEMP_W-1:0] TEMP_RESET = 8'sh00;
  // ==========================================================================
  // condition states
  typedef enum logic [2:0] {
    COND_NORMAL = 3'b001,
    COND_WARNING = 3'b010,
    COND_ERROR = 3'b100
  } cond_state_e;
endpackage : die_temperature_guard_pkg

// ---- hdl/repeat_timer.sv ----
/*
  Period timer, held at zero while run_i is low, that pulses once per period and restarts on demand.
  Assumes the restart request is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
module repeat_timer #(
  parameter int TIMER_W = 32,
  parameter longint PERIOD = 125000000
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic restart_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(PERIOD - 1);
  logic [TIMER_W-1:0] count;
  logic [TIMER_W-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (restart_i || !run_i) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + TIMER_W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end
endmodule : repeat_timer

// ---- hdl/die_temperature_guard.sv ----
/*
  Die temperature guard: tracks the on-die sensor reading, runs a warning and
  an error condition with hysteresis, re-posts notifications once a second and,
  in the protecting variant, halts acquisition in the error condition.
  Assumes the sensor delivers signed whole degrees with a one-cycle valid strobe.
*/
// Overview of operation
// (R1) on-die sensor reading is reported to host in degrees Celsius
// (R2) host selects own-die source first, then reads temperature
// (R3) reaching 87 degrees enters warning and posts warning notification
// (R4) warning repeats each second; ends below 83 or above 103 (the code already leaves warning at 103)
// (R5) reaching 103 degrees enters error and posts critical notification
// (R6) protecting variant halts acquisition in error; notify-only variant does not
// (R7) error repeats critical notification each second until below 97
// (R8) one-second timer restarts on entry; state resets to normal
`timescale 1ns/10ps
module die_temperature_guard
  import die_temperature_guard_pkg::*;
#(
  parameter bit AUTO_STOP = 1'b1,
  parameter longint REPEAT_CYCLES_P = REPEAT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic signed [TEMP_W-1:0] sensor_temp_i,
  input wire logic sensor_valid_i,
  input wire logic [SRC_W-1:0] temp_source_select_i,
  output logic signed [TEMP_W-1:0] temp_degc_o,
  output logic temp_valid_o,
  output logic warn_notify_o,
  output logic crit_notify_o,
  output logic warn_active_o,
  output logic err_active_o,
  output logic acq_halt_o
);
  // ==========================================================================
  // measurement capture
  cond_state_e state;
  cond_state_e next_state;
  logic signed [TEMP_W-1:0] meas;
  logic signed [TEMP_W-1:0] next_meas;
  logic meas_ok;
  logic next_meas_ok;
  logic signed [TEMP_W-1:0] next_temp_degc;
  logic next_temp_valid;
  logic tick;
  logic restart;
  logic next_warn_notify;
  logic next_crit_notify;
  logic next_acq_halt;
  logic next_warn_active;
  logic next_err_active;

  // ==========================================================================
  // threshold and source decoding
  // entry compares are inclusive and exit compares strict, so a reading that
  // sits on a threshold never flips the condition back and forth

  // (R2) own-die source code
  function automatic logic own_die_selected(input logic [SRC_W-1:0] sel);
    return sel == SRC_OWN_DIE;
  endfunction : own_die_selected

  // (R5) error entry level
  function automatic logic reaches_error(input logic signed [TEMP_W-1:0] t);
    return t >= ERR_SET_DEGC;
  endfunction : reaches_error

  // (R3) warning entry level
  function automatic logic reaches_warning(input logic signed [TEMP_W-1:0] t);
    return t >= WARN_SET_DEGC;
  endfunction : reaches_warning

  // (R7) error exit level
  function automatic logic below_error_clear(input logic signed [TEMP_W-1:0] t);
    return t < ERR_CLEAR_DEGC;
  endfunction : below_error_clear

  // (R4) warning exit level
  function automatic logic below_warning_clear(input logic signed [TEMP_W-1:0] t);
    return t < WARN_CLEAR_DEGC;
  endfunction : below_warning_clear

  // (R1) own-die reading reported
  // (R2) only valid under own-die source
  always_comb begin
    next_meas = meas;
    next_meas_ok = meas_ok;
    next_temp_degc = temp_degc_o;
    next_temp_valid = own_die_selected(temp_source_select_i) && meas_ok;
    if (sensor_valid_i) begin
      next_meas = sensor_temp_i;
      next_meas_ok = 1'b1;
    end
    if (own_die_selected(temp_source_select_i)) begin
      // a foreign source freezes the last own-die reading rather than zeroing it
      next_temp_degc = meas;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meas <= TEMP_RESET;
      meas_ok <= 1'b0;
      temp_degc_o <= TEMP_RESET;
      temp_valid_o <= 1'b0;
    end else begin
      meas <= next_meas;
      meas_ok <= next_meas_ok;
      temp_degc_o <= next_temp_degc;
      temp_valid_o <= next_temp_valid;
    end
  end

  // ==========================================================================
  // condition state machine
  // error checked first: a jump straight past 103 lands in error, not warning
  always_comb begin
    next_state = state;
    restart = 1'b0;
    if (meas_ok) begin
      unique case (state)
        COND_NORMAL: begin
          // (R5) error entry
          if (reaches_error(meas)) begin
            next_state = COND_ERROR;
            restart = 1'b1;
          // (R3) warning entry
          end else if (reaches_warning(meas)) begin
            next_state = COND_WARNING;
            restart = 1'b1;
          end
        end
        COND_WARNING: begin
          // (R4) warning exit points
          if (reaches_error(meas)) begin
            next_state = COND_ERROR;
            restart = 1'b1;
          end else if (below_warning_clear(meas)) begin
            next_state = COND_NORMAL;
          end
        end
        COND_ERROR: begin
          // (R7) error holds until below 97
          if (below_error_clear(meas)) begin
            // still hot enough to warn: a fresh warning entry, new post and new pacing
            if (reaches_warning(meas)) begin
              next_state = COND_WARNING;
              restart = 1'b1;
            end else begin
              next_state = COND_NORMAL;
            end
          end
        end
        default: begin
          // illegal one-hot code: fall back to the safe state
          next_state = COND_NORMAL;
        end
      endcase
    end
  end

  // (R8) reset to normal
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= COND_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // repeat pacing
  // the timer idles at zero in normal, so the first repeat post lands a full period plus one cycle after the entry post
  // (R8) one-second timer, restarted on entry
  repeat_timer #(
    .TIMER_W(TIMER_W),
    .PERIOD(REPEAT_CYCLES_P)
  ) u_repeat_timer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(restart),
    .run_i(state != COND_NORMAL),
    .tick_o(tick)
  );

  // ==========================================================================
  // notifications and acquisition halt
  always_comb begin
    next_warn_notify = 1'b0;
    next_crit_notify = 1'b0;
    // (R3) post on entry, (R4) repeat per tick
    if (restart && next_state == COND_WARNING) begin
      next_warn_notify = 1'b1;
    end else if (!restart && tick && state == COND_WARNING) begin
      next_warn_notify = 1'b1;
    end
    // (R5) post on entry, (R7) repeat per tick
    if (restart && next_state == COND_ERROR) begin
      next_crit_notify = 1'b1;
    end else if (!restart && tick && state == COND_ERROR) begin
      next_crit_notify = 1'b1;
    end
    next_warn_active = (next_state == COND_WARNING);
    next_err_active = (next_state == COND_ERROR);
    // (R6) halt only in protecting variant
    next_acq_halt = AUTO_STOP && next_err_active;
  end

  // registered so levels and pulses change together, one edge after the state decision
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      warn_notify_o <= 1'b0;
      crit_notify_o <= 1'b0;
      warn_active_o <= 1'b0;
      err_active_o <= 1'b0;
      acq_halt_o <= 1'b0;
    end else begin
      warn_notify_o <= next_warn_notify;
      crit_notify_o <= next_crit_notify;
      warn_active_o <= next_warn_active;
      err_active_o <= next_err_active;
      acq_halt_o <= next_acq_halt;
    end
  end
endmodule : die_temperature_guard

// ---- dv/die_temperature_guard_props.sv ----
/*
  Port-level checker for the die temperature guard, bound to every instance.
  Assumes one clock, async active-high reset, answers two edges after capture.
*/
`timescale 1ns/10ps
module die_temperature_guard_props
  import die_temperature_guard_pkg::*;
#(
  parameter bit AUTO_STOP = 1'b1,
  parameter longint REPEAT_CYCLES_P = REPEAT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic signed [TEMP_W-1:0] sensor_temp_i,
  input wire logic sensor_valid_i,
  input wire logic [SRC_W-1:0] temp_source_select_i,
  input wire logic temp_valid_o,
  input wire logic warn_notify_o,
  input wire logic crit_notify_o,
  input wire logic warn_active_o,
  input wire logic err_active_o,
  input wire logic acq_halt_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] wc;
  logic [31:0] cc;
  logic [1:0] vh;
  logic q;
  // ==========================================================================
  // helpers
  // a sample in the two edges before still moves the outputs, so skip those
  assign q = sensor_valid_i && vh == 2'h0;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wc <= 32'h0;
      cc <= 32'h0;
      vh <= 2'h0;
    end else begin
      wc <= (warn_notify_o || !warn_active_o) ? 32'h0 : wc + 32'h1;
      cc <= (crit_notify_o || !err_active_o) ? 32'h0 : cc + 32'h1;
      vh <= {vh[0], sensor_valid_i};
    end
  end
  // ==========================================================================
  // properties
  property p_warn_set;
    q && sensor_temp_i >= WARN_SET_DEGC && sensor_temp_i < ERR_SET_DEGC && !warn_active_o && !err_active_o
      |-> ##2 warn_active_o && warn_notify_o;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning entry missed");
  property p_err_set;
    q && sensor_temp_i >= ERR_SET_DEGC && !err_active_o |-> ##2 err_active_o && crit_notify_o && !warn_active_o;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error entry missed");
  property p_warn_clr;
    q && sensor_temp_i < WARN_CLEAR_DEGC && warn_active_o |-> ##2 !warn_active_o && !err_active_o;
  endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning not cleared");
  property p_err_clr;
    q && sensor_temp_i < ERR_CLEAR_DEGC && sensor_temp_i >= WARN_SET_DEGC && err_active_o
      |-> ##2 !err_active_o && warn_active_o && warn_notify_o;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error exit wrong");
  property p_halt;
    acq_halt_o == (AUTO_STOP && err_active_o);
  endproperty
  a_halt: assert property (p_halt) else $error("halt level wrong");
  property p_warn_rep;
    wc <= REPEAT_CYCLES_P + 2;
  endproperty
  a_warn_rep: assert property (p_warn_rep) else $error("warning repeat late");
  property p_crit_rep;
    cc <= REPEAT_CYCLES_P + 2;
  endproperty
  a_crit_rep: assert property (p_crit_rep) else $error("critical repeat late");
  property p_src;
    temp_source_select_i != SRC_OWN_DIE |=> !temp_valid_o;
  endproperty
  a_src: assert property (p_src) else $error("valid with foreign source");
  c_warn: cover property (warn_notify_o);
  c_crit: cover property (crit_notify_o);
  c_halt: cover property ($rose(acq_halt_o));
endmodule : die_temperature_guard_props

bind die_temperature_guard die_temperature_guard_props #(.AUTO_STOP(AUTO_STOP), .REPEAT_CYCLES_P(REPEAT_CYCLES_P))
  u_props (.mclk_i, .sys_rst_i, .sensor_temp_i, .sensor_valid_i, .temp_source_select_i, .temp_valid_o,
  .warn_notify_o, .crit_notify_o, .warn_active_o, .err_active_o, .acq_halt_o);

// ---- dv/die_temperature_guard_tb_top.sv ----
/*
  Self-checking bench for the die temperature guard, both variants side by side.
  Assumes a 20-cycle repeat period in place of one second.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module die_temperature_guard_tb_top import die_temperature_guard_pkg::*;;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic signed [TEMP_W-1:0] sensor_temp_i = 8'sh00;
  logic sensor_valid_i = 1'b0;
  logic [SRC_W-1:0] temp_source_select_i = SRC_OWN_DIE;
  logic signed [TEMP_W-1:0] temp_degc_o;
  logic temp_valid_o, warn_notify_o, crit_notify_o, warn_active_o, err_active_o, acq_halt_o, halt_b;
  int num_errors = 0;
  int comparisons = 0;
  localparam int REP = 20;
  always #4 mclk_i = ~mclk_i;
  die_temperature_guard #(.AUTO_STOP(1'b1), .REPEAT_CYCLES_P(REP)) DUT (.mclk_i, .sys_rst_i, .sensor_temp_i,
    .sensor_valid_i, .temp_source_select_i, .temp_degc_o, .temp_valid_o, .warn_notify_o, .crit_notify_o,
    .warn_active_o, .err_active_o, .acq_halt_o);
  // notify-only variant shares the stimulus
  die_temperature_guard #(.AUTO_STOP(1'b0), .REPEAT_CYCLES_P(REP)) dut_notify (.mclk_i, .sys_rst_i, .sensor_temp_i,
    .sensor_valid_i, .temp_source_select_i, .temp_degc_o(), .temp_valid_o(), .warn_notify_o(), .crit_notify_o(),
    .warn_active_o(), .err_active_o(), .acq_halt_o(halt_b));
  // ==========================================================================
  // helpers
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // one sample; returns while its answer, entry pulse included, still stands
  task automatic put(input logic signed [TEMP_W-1:0] t);
    @(negedge mclk_i);
    sensor_temp_i = t;
    sensor_valid_i = 1'b1;
    @(negedge mclk_i);
    sensor_valid_i = 1'b0;
    @(negedge mclk_i);
  endtask : put
  task automatic t_repeat(input logic crit);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (n < 40 && (crit ? crit_notify_o : warn_notify_o) !== 1'b1) begin
      n++;
      @(negedge mclk_i);
    end
    `CHK(n, REP)
    if (n >= 40) print_verdict();
  endtask : t_repeat
  // ==========================================================================
  // scenarios
  task automatic t_warn();
    put(8'sd86);
    `CHK({warn_active_o, temp_valid_o, temp_degc_o}, 10'h156)
    put(WARN_SET_DEGC);
    `CHK({warn_active_o, warn_notify_o, err_active_o}, 3'h6)
  endtask : t_warn
  task automatic t_err();
    put(ERR_SET_DEGC);
    `CHK({err_active_o, crit_notify_o, warn_active_o, acq_halt_o, halt_b}, 5'h1A)
    t_repeat(1'b1);
    put(ERR_CLEAR_DEGC);
    `CHK({err_active_o, acq_halt_o}, 2'h3)
    put(8'sd96);
    `CHK({err_active_o, warn_active_o, warn_notify_o, acq_halt_o}, 4'h6)
    put(WARN_CLEAR_DEGC);
    `CHK(warn_active_o, 1'b1)
    put(8'sd82);
    `CHK(warn_active_o, 1'b0)
  endtask : t_err
  task automatic t_src();
    temp_source_select_i = 2'h1;
    put(8'sd50);
    `CHK({temp_valid_o, temp_degc_o}, 9'h052)
    temp_source_select_i = SRC_OWN_DIE;
    put(8'sd60);
    `CHK({temp_valid_o, temp_degc_o}, 9'h13C)
  endtask : t_src
  task automatic t_rst();
    put(8'sd90);
    sys_rst_i = 1'b1;
    @(negedge mclk_i);
    `CHK({warn_active_o, temp_valid_o}, 2'h0)
    sys_rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    `CHK({warn_active_o, warn_notify_o, temp_valid_o}, 3'h0)
  endtask : t_rst
  initial begin
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_warn();
    t_repeat(1'b0);
    t_err();
    t_src();
    t_rst();
    print_verdict();
  end
endmodule : die_temperature_guard_tb_top
